//--- hw/comp_pkg.sv
package comp_pkg;

  // ==========================================================================
  // register byte offsets (only haddr[11:2] is decoded)
  // ==========================================================================
  localparam logic [11:0] OFF_START      = 12'h000;
  localparam logic [11:0] OFF_STOP       = 12'h004;
  localparam logic [11:0] OFF_SAMPLE     = 12'h008;
  localparam logic [11:0] OFF_EV_READY   = 12'h100;
  localparam logic [11:0] OFF_EV_DOWN    = 12'h104;
  localparam logic [11:0] OFF_EV_UP      = 12'h108;
  localparam logic [11:0] OFF_EV_CROSSING_EVENT   = 12'h10c;
  localparam logic [11:0] OFF_EVENT_SHORTCUT_ENABLES     = 12'h200;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_MASK      = 12'h300;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_SET   = 12'h304;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_CLEAR   = 12'h308;
  localparam logic [11:0] OFF_RESULT     = 12'h400;
  localparam logic [11:0] OFF_ENABLE     = 12'h500;
  localparam logic [11:0] OFF_PSEL       = 12'h504;
  localparam logic [11:0] OFF_REFERENCE_SOURCE_SELECT     = 12'h508;
  localparam logic [11:0] OFF_EXTERNAL_REFERENCE_SELECT  = 12'h50c;
  localparam logic [11:0] OFF_TH         = 12'h530;
  localparam logic [11:0] OFF_MODE       = 12'h534;
  localparam logic [11:0] OFF_HYSTERESIS_ENABLE       = 12'h538;

  // ==========================================================================
  // fields and values
  // ==========================================================================
  localparam logic [1:0]  ENABLE_ON      = 2'h2;
  localparam logic [1:0]  ENABLE_OFF     = 2'h0;
  localparam logic [2:0]  REFERENCE_SOURCE_SELECT_RESET   = 3'h4;
  localparam logic [2:0]  REF_INT_LAST   = 3'h2;
  localparam logic [2:0]  REF_EXTERNAL   = 3'h5;
  localparam logic [2:0]  PSEL_HALF_VDD  = 3'h7;
  localparam logic [1:0]  SPEED_LOW      = 2'h0;
  localparam logic [1:0]  SPEED_NORMAL   = 2'h1;
  localparam logic [1:0]  SPEED_HIGH     = 2'h2;
  localparam int          TH_DOWN_LSB    = 0;
  localparam int          TH_UP_LSB      = 8;
  localparam int          MODE_DIFF_BIT  = 8;
  localparam int          EV_READY       = 0;
  localparam int          EV_DOWN        = 1;
  localparam int          EV_UP          = 2;
  localparam int          EV_CROSSING_EVENT       = 3;
  localparam int          SH_READY_SAMPLE = 0;
  localparam int          SH_READY_STOP  = 1;
  localparam int          SH_DOWN_STOP   = 2;
  localparam int          SH_UP_STOP     = 3;
  localparam int          SH_CROSSING_TO_HALT_SHORTCUT  = 4;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          STARTUP_US     = 3;
  localparam int          STARTUP_CYCLES =
    (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  STARTUP_LOAD   = 8'(STARTUP_CYCLES - 1);

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {ST_OFF, ST_STARTUP, ST_RUNNING} run_state_e;

  typedef struct packed {
    logic       connect;
    logic       power;
    logic       diff_mode;
    logic       hysteresis_enable_on;
    logic [1:0] speed;
    logic [2:0] pos_sel;
    logic [2:0] ref_sel;
    logic [2:0] ext_ref_sel;
    logic [5:0] ladder_code;
    logic       use_lower;
  } core_ctrl_s;

  typedef struct packed {
    logic above;
    logic core_ready;
    logic ref_ready;
  } core_stat_s;

  typedef struct packed {
    logic level;
    logic up;
    logic down;
    logic crossing_event;
  } crossing_event_s;

  // internal references need their own ready only in single-ended operation
  function automatic logic needs_ref_ready(input logic diff, input logic [2:0] reference_source_select);
    return !diff && (reference_source_select <= REF_INT_LAST);
  endfunction

endpackage

//--- hw/crossing_detector.sv
`timescale 1ns/1ps
module crossing_detector
  import comp_pkg::*;
(
  // clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // comparator level and arming
  input  wire logic   arm,
  input  wire logic   above,
  // registered level and one-cycle crossing pulses
  output crossing_event_s      det
);

  crossing_event_s s_reg;
  crossing_event_s s_next;

  // ==========================================================================
  // edge detection
  // ==========================================================================
  always_comb begin
    s_next       = s_reg;
    s_next.level = above;
    s_next.up    = arm && above && !s_reg.level;
    s_next.down  = arm && !above && s_reg.level;
    s_next.crossing_event = arm && (above != s_reg.level);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign det = s_reg;

  a_crossing_event_any_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.up || s_reg.down) |-> s_reg.crossing_event)
    else $error("directional event without crossing event");

endmodule // crossing_detector

//--- hw/comparator_control_logic.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module comparator_control_logic
  import comp_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog comparator core and reference ladder
  input  wire core_stat_s  core_stat,
  output core_ctrl_s       core_ctrl,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    run_state_e  st;
    logic [7:0]  cnt;
    logic [3:0]  ev;
    logic [4:0]  event_shortcut_enables;
    logic [3:0]  interrupt_enable_mask;
    logic        result;
    logic [1:0]  enable;
    logic [2:0]  psel;
    logic [2:0]  reference_source_select;
    logic [2:0]  extref;
    logic [5:0]  upper_threshold_field;
    logic [5:0]  lower_threshold_field;
    logic [1:0]  speed;
    logic        diff;
    logic        hysteresis_enable;
    logic        pend;
    logic        pend_wr;
    logic [11:0] addr;
    logic        readyout;
    logic        resp;
    logic [31:0] rdata;
    logic        irq;
    core_ctrl_s  ctrl;
  } state_s;

  state_s s_reg;
  state_s s_next;
  crossing_event_s det;

  logic   acc;
  logic   wr_now;
  logic   t_start;
  logic   t_stop;
  logic   t_sample;
  logic   ready_ev;
  logic   sample_t;
  logic   stop_t;
  logic   enabled;
  logic   [3:0] ev_set;
  logic   [3:0] ev_clr;

  // ==========================================================================
  // crossing detection
  // ==========================================================================
  crossing_detector u_det (
    .hclk    (hclk),
    .hresetn (hresetn),
    .arm     (s_reg.st == ST_RUNNING),
    .above   (core_stat.above),
    .det     (det)
  );

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_next   = s_reg;
    t_start  = 1'b0;
    t_stop   = 1'b0;
    t_sample = 1'b0;
    ev_clr   = 4'h0;

    // bus: address phase, then one wait cycle where the access is done
    acc    = hsel && hready && htrans[1];
    wr_now = s_reg.pend && s_reg.pend_wr;
    if (acc) begin
      s_next.pend     = 1'b1;
      s_next.pend_wr  = hwrite;
      s_next.addr     = {haddr[11:2], 2'b00};
      s_next.readyout = 1'b0;
    end
    if (s_reg.pend) begin
      s_next.pend     = 1'b0;
      s_next.readyout = 1'b1;
      s_next.rdata    = 32'h0;
    end

    if (wr_now) begin
      case (s_reg.addr)
        OFF_START:    t_start  = hwdata[0];
        OFF_STOP:     t_stop   = hwdata[0];
        OFF_SAMPLE:   t_sample = hwdata[0];
        OFF_EV_READY, OFF_EV_DOWN, OFF_EV_UP, OFF_EV_CROSSING_EVENT: begin
          ev_clr[s_reg.addr[3:2]] = (hwdata == 32'h0);
        end
        OFF_EVENT_SHORTCUT_ENABLES:   s_next.event_shortcut_enables = hwdata[4:0];
        OFF_INTERRUPT_ENABLE_MASK:    s_next.interrupt_enable_mask  = hwdata[3:0];
        OFF_INTERRUPT_ENABLE_SET: s_next.interrupt_enable_mask  = s_reg.interrupt_enable_mask | hwdata[3:0];
        OFF_INTERRUPT_ENABLE_CLEAR: s_next.interrupt_enable_mask  = s_reg.interrupt_enable_mask & ~hwdata[3:0];
        OFF_ENABLE:   s_next.enable = hwdata[1:0];
        OFF_PSEL:     s_next.psel   = hwdata[2:0];
        OFF_REFERENCE_SOURCE_SELECT:   s_next.reference_source_select = hwdata[2:0];
        OFF_EXTERNAL_REFERENCE_SELECT: s_next.extref = hwdata[2:0];
        OFF_TH: begin
          s_next.lower_threshold_field = hwdata[TH_DOWN_LSB +: 6];
          s_next.upper_threshold_field   = hwdata[TH_UP_LSB +: 6];
        end
        OFF_MODE: begin
          s_next.speed = hwdata[1:0];
          s_next.diff  = hwdata[MODE_DIFF_BIT];
        end
        OFF_HYSTERESIS_ENABLE:     s_next.hysteresis_enable   = hwdata[0];
        default: begin
        end
      endcase
    end else if (s_reg.pend) begin
      case (s_reg.addr)
        OFF_EV_READY, OFF_EV_DOWN, OFF_EV_UP, OFF_EV_CROSSING_EVENT: begin
          s_next.rdata = {31'h0, s_reg.ev[s_reg.addr[3:2]]};
        end
        OFF_EVENT_SHORTCUT_ENABLES:    s_next.rdata = {27'h0, s_reg.event_shortcut_enables};
        OFF_INTERRUPT_ENABLE_MASK, OFF_INTERRUPT_ENABLE_SET, OFF_INTERRUPT_ENABLE_CLEAR: begin
          s_next.rdata = {28'h0, s_reg.interrupt_enable_mask};
        end
        OFF_RESULT:    s_next.rdata = {31'h0, s_reg.result};
        OFF_ENABLE:    s_next.rdata = {30'h0, s_reg.enable};
        OFF_PSEL:      s_next.rdata = {29'h0, s_reg.psel};
        OFF_REFERENCE_SOURCE_SELECT:    s_next.rdata = {29'h0, s_reg.reference_source_select};
        OFF_EXTERNAL_REFERENCE_SELECT: s_next.rdata = {29'h0, s_reg.extref};
        OFF_TH:        s_next.rdata = {18'h0, s_reg.upper_threshold_field, 2'h0, s_reg.lower_threshold_field};
        OFF_MODE:      s_next.rdata = {23'h0, s_reg.diff, 6'h0, s_reg.speed};
        OFF_HYSTERESIS_ENABLE:      s_next.rdata = {31'h0, s_reg.hysteresis_enable};
        default:       s_next.rdata = 32'h0;
      endcase
    end

    // ready needs elapsed wait, core ready and reference ready if used
    ready_ev = (s_reg.st == ST_STARTUP) && (s_reg.cnt == 8'h0) &&
               core_stat.core_ready &&
               (core_stat.ref_ready || !needs_ref_ready(s_reg.diff, s_reg.reference_source_select));

    sample_t = t_sample || (ready_ev && s_reg.event_shortcut_enables[SH_READY_SAMPLE]);
    stop_t   = t_stop ||
               (ready_ev  && s_reg.event_shortcut_enables[SH_READY_STOP]) ||
               (det.down  && s_reg.event_shortcut_enables[SH_DOWN_STOP]) ||
               (det.up    && s_reg.event_shortcut_enables[SH_UP_STOP]) ||
               (det.crossing_event && s_reg.event_shortcut_enables[SH_CROSSING_TO_HALT_SHORTCUT]);

    // run control; enable taken from the value after this cycle's write
    enabled = (s_next.enable == ENABLE_ON);
    if (!enabled) begin
      s_next.st  = ST_OFF;
      s_next.cnt = 8'h0;
    end else begin
      case (s_reg.st)
        ST_OFF: begin
          if (t_start && !stop_t) begin
            s_next.st  = ST_STARTUP;
            s_next.cnt = STARTUP_LOAD;
          end
        end
        ST_STARTUP: begin
          if (stop_t) begin
            s_next.st = ST_OFF;
          end else if (s_reg.cnt != 8'h0) begin
            s_next.cnt = s_reg.cnt - 8'h1;
          end else if (ready_ev) begin
            s_next.st = ST_RUNNING;
          end
        end
        ST_RUNNING: begin
          if (stop_t) begin
            s_next.st = ST_OFF;
          end
        end
        default: s_next.st = ST_OFF;
      endcase
    end

    if (sample_t && (s_reg.enable == ENABLE_ON)) begin
      s_next.result = core_stat.above;
    end

    // sticky events: a set in the clearing cycle wins
    ev_set = {det.crossing_event, det.up, det.down, ready_ev};
    s_next.ev  = (s_reg.ev & ~ev_clr) | ev_set;
    s_next.irq = |(s_next.ev & s_next.interrupt_enable_mask);

    // analog controls
    s_next.ctrl.connect     = enabled;
    s_next.ctrl.power       = (s_next.st != ST_OFF);
    s_next.ctrl.diff_mode   = s_next.diff;
    s_next.ctrl.hysteresis_enable_on     = s_next.diff && s_next.hysteresis_enable;
    s_next.ctrl.speed       = s_next.speed;
    s_next.ctrl.pos_sel     = s_next.psel;
    s_next.ctrl.ref_sel     = s_next.reference_source_select;
    s_next.ctrl.ext_ref_sel = s_next.extref;
    s_next.ctrl.use_lower   = !s_next.diff && det.level;
    s_next.ctrl.ladder_code = s_next.ctrl.use_lower ? s_next.lower_threshold_field
                                                    : s_next.upper_threshold_field;
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg          <= '0;
      s_reg.reference_source_select   <= REFERENCE_SOURCE_SELECT_RESET;
      s_reg.readyout <= 1'b1;
      s_reg.ctrl.ref_sel <= REFERENCE_SOURCE_SELECT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.readyout;
  assign hresp     = s_reg.resp;
  assign hrdata    = s_reg.rdata;
  assign core_ctrl = s_reg.ctrl;
  assign irq       = s_reg.irq;

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_off_when_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.enable != ENABLE_ON) |-> (s_reg.st == ST_OFF))
    else $error("comparator running while disabled");

  a_stop_halts: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop_t && s_reg.st != ST_OFF) |=> (s_reg.st == ST_OFF))
    else $error("stop trigger did not halt comparator");

  a_startup_load: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.st == ST_STARTUP) |-> (s_reg.cnt == STARTUP_LOAD))
    else $error("start-up wait not loaded");

  a_ready_after_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.st == ST_RUNNING) |->
      ($past(s_reg.cnt) == 8'h0) && s_reg.ev[EV_READY])
    else $error("ready before start-up wait ended");

  a_ready_needs_core: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.st == ST_RUNNING) |-> $past(core_stat.core_ready))
    else $error("ready raised without core ready");

  a_ready_needs_ref: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.st == ST_RUNNING) |->
      ($past(core_stat.ref_ready) || !needs_ref_ready($past(s_reg.diff), $past(s_reg.reference_source_select))))
    else $error("ready raised without reference ready");

  a_up_event_set: assert property (@(posedge hclk) disable iff (!hresetn)
    det.up |=> s_reg.ev[EV_UP] && s_reg.ev[EV_CROSSING_EVENT])
    else $error("upward crossing not flagged");

  a_down_event_set: assert property (@(posedge hclk) disable iff (!hresetn)
    det.down |=> s_reg.ev[EV_DOWN] && s_reg.ev[EV_CROSSING_EVENT])
    else $error("downward crossing not flagged");

  a_sample_result: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && s_reg.addr == OFF_SAMPLE && hwdata[0] && s_reg.enable == ENABLE_ON)
      |=> (s_reg.result == $past(core_stat.above)))
    else $error("sample did not capture output");

  a_connect_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg.ctrl.connect == (s_reg.enable == ENABLE_ON))
    else $error("pin connection does not follow enable");

  a_lower_while_above: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s_reg.diff ##1 !s_reg.diff) |-> (s_reg.ctrl.use_lower == $past(det.level)))
    else $error("wrong ladder threshold selected");

  a_hysteresis_enable_single_off: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg.ctrl.hysteresis_enable_on |-> s_reg.diff)
    else $error("hysteresis applied in single-ended mode");

  a_event_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.ev[EV_READY] && !(wr_now && s_reg.addr == OFF_EV_READY)) |=> s_reg.ev[EV_READY])
    else $error("event flag lost without clear");

  a_irq_from_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg.irq == (|(s_reg.ev & s_reg.interrupt_enable_mask)))
    else $error("interrupt does not match masked events");

  a_trigger_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.pend && !s_reg.pend_wr && s_reg.addr <= OFF_SAMPLE) |=> (s_reg.rdata == 32'h0))
    else $error("trigger register read nonzero");

  a_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    acc |=> !s_reg.readyout ##1 s_reg.readyout)
    else $error("bus answer not after one wait cycle");

  c_ready_event: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.ev[EV_READY]));
  c_up_event: cover property (@(posedge hclk) disable iff (!hresetn)
    det.up);
  c_shortcut_stop: cover property (@(posedge hclk) disable iff (!hresetn)
    (s_reg.st == ST_RUNNING) && stop_t && !t_stop);
  c_ready_sample: cover property (@(posedge hclk) disable iff (!hresetn)
    ready_ev && s_reg.event_shortcut_enables[SH_READY_SAMPLE]);

endmodule // comparator_control_logic

//--- bench/comp_core_model.sv
`timescale 1ns/1ps
// ==========================================================================
// analog core and reference ladder model
// ==========================================================================
module comp_core_model
  import comp_pkg::*;
(
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // pin levels in ladder steps, reference start-up delay
  input  wire logic [7:0][5:0] ain,
  input  wire logic [7:0]      ref_dly,
  // control and status
  input  wire core_ctrl_s      core_ctrl,
  output core_stat_s           core_stat
);
  logic [7:0] cnt;
  logic       abv;
  logic [6:0] vp;
  logic [6:0] vn;
  assign vp = (core_ctrl.pos_sel == PSEL_HALF_VDD) ? 7'd32 : 7'(ain[core_ctrl.pos_sel]);
  assign vn = core_ctrl.diff_mode ? 7'(ain[core_ctrl.ext_ref_sel])
                                  : 7'(core_ctrl.ladder_code);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      abv <= 1'b0;
    end else if (!core_ctrl.power) begin
      cnt <= '0;
      // unpowered core output rests low
      abv <= 1'b0;
    end else begin
      cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h1;
      if (core_ctrl.hysteresis_enable_on) begin
        abv <= abv ? (vp + 7'd1 >= vn) : (vp > vn + 7'd1);
      end else begin
        abv <= vp > vn;
      end
    end
  end
  assign core_stat = '{above: abv, core_ready: (cnt >= 8'd100), ref_ready: (cnt >= ref_dly)};
endmodule // comp_core_model

//--- bench/comparator_control_logic_tb.sv
`timescale 1ns/1ps
module comparator_control_logic_tb
  import comp_pkg::*;
;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic             hwrite;
  logic             hready;
  logic             hreadyout;
  logic             hresp;
  logic             irq;
  logic             diff;
  logic             rdy_exp;
  logic [1:0]       htrans;
  logic [1:0]       spd;
  logic [2:0]       hsize;
  logic [2:0]       psel;
  logic [2:0]       ext;
  logic [2:0]       refs;
  logic [5:0]       upper_threshold_field;
  logic [5:0]       thdn;
  logic [7:0]       ref_dly;
  logic [31:0]      haddr;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic [31:0]      rd;
  logic [7:0][5:0]  ain;
  core_stat_s       core_stat;
  core_ctrl_s       core_ctrl;
  int               err_total = 0;
  int               comparisons = 0;
  int               seed = 32'hd87f;
  logic [2:0]       refpick [5] = '{3'h0, 3'h1, 3'h2, 3'h4, REF_EXTERNAL};
  logic [11:0]      ra [6] = '{OFF_EVENT_SHORTCUT_ENABLES, OFF_INTERRUPT_ENABLE_MASK, OFF_ENABLE, OFF_REFERENCE_SOURCE_SELECT, OFF_START, 12'h600};
  logic [31:0]      rv [6] = '{32'h0, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0};

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  assign hready = hreadyout;

  comparator_control_logic dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_stat(core_stat),
    .core_ctrl(core_ctrl), .irq(irq));
  comp_core_model core_u (.hclk(hclk), .hresetn(hresetn), .ain(ain), .ref_dly(ref_dly),
    .core_ctrl(core_ctrl), .core_stat(core_stat));

  // ==========================================================================
  // checking and bus tasks
  // ==========================================================================
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdy_wait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      cmp("hreadyout", 32'h1, 32'(hreadyout));
      results();
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    rd = hrdata;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(nm, exp, rd);
    cmp("hresp", 32'h0, 32'(hresp));
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    ain = '0;
    ref_dly = 8'd220;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 12'h600, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      rdc("reset value", ra[i], rv[i]);
    end
    bus(1'b1, OFF_START, 32'h1);
    repeat (200) @(posedge hclk);
    rdc("start disabled", OFF_EV_READY, 32'h0);
    for (int it = 0; it < 3; it++) begin
      diff = (it == 1);
      spd = 2'(it);
      psel = 3'($unsigned($random(seed)) % 7);
      ext = psel + 3'h1;
      upper_threshold_field = 6'(32 + $unsigned($random(seed)) % 30);
      thdn = 6'($unsigned($random(seed)) % 32);
      refs = refpick[$unsigned($random(seed)) % 5];
      ain <= 48'(upper_threshold_field) << (6 * ext);
      ref_dly <= (it == 2) ? 8'd20 : 8'd220;
      bus(1'b1, OFF_ENABLE, 32'(ENABLE_OFF));
      repeat (2) @(posedge hclk);
      cmp("connect", 32'h0, 32'(core_ctrl.connect));
      bus(1'b1, OFF_PSEL, 32'(psel));
      bus(1'b1, OFF_MODE, {23'h0, diff, 6'h0, spd});
      bus(1'b1, OFF_REFERENCE_SOURCE_SELECT, 32'(refs));
      bus(1'b1, OFF_EXTERNAL_REFERENCE_SELECT, 32'(ext));
      bus(1'b1, OFF_TH, {18'h0, upper_threshold_field, 2'h0, thdn});
      bus(1'b1, OFF_HYSTERESIS_ENABLE, 32'h1);
      bus(1'b1, OFF_ENABLE, 32'(ENABLE_ON));
      repeat (2) @(posedge hclk);
      rd = 32'({2'b10, diff, diff, spd});
      cmp("ctrl mode", rd, 32'(core_ctrl[21:16]));
      rd = 32'({psel, refs, ext, upper_threshold_field, 1'b0});
      cmp("ctrl select", rd, 32'(core_ctrl[15:0]));
      rdy_exp = !(!diff && refs <= 3'h2 && ref_dly > 8'd200);
      bus(1'b1, OFF_EVENT_SHORTCUT_ENABLES, 32'h1 << SH_READY_SAMPLE);
      bus(1'b1, OFF_START, 32'h1);
      repeat (140) @(posedge hclk);
      rdc("ready early", OFF_EV_READY, 32'h0);
      repeat (58) @(posedge hclk);
      rdc("ready ref", OFF_EV_READY, 32'(rdy_exp));
      for (int n = 0; n < 200 && rd[0] !== 1'b1; n++) begin
        bus(1'b0, OFF_EV_READY, 32'h0);
      end
      cmp("ready", 32'h1, rd);
      rdc("result ready", OFF_RESULT, 32'h0);
      bus(1'b1, OFF_INTERRUPT_ENABLE_SET, 32'h1 << EV_UP);
      rdc("mask", OFF_INTERRUPT_ENABLE_MASK, 32'h4);
      bus(1'b1, OFF_SAMPLE, 32'h1);
      rdc("result low", OFF_RESULT, 32'h0);
      ain[psel] <= 6'd63;
      repeat (6) @(posedge hclk);
      rdc("up", OFF_EV_UP, 32'h1);
      rdc("crossing_event", OFF_EV_CROSSING_EVENT, 32'h1);
      rdc("down", OFF_EV_DOWN, 32'h0);
      cmp("irq", 32'h1, 32'(irq));
      cmp("lower", 32'({(diff ? upper_threshold_field : thdn), !diff}), 32'(core_ctrl[6:0]));
      bus(1'b1, OFF_SAMPLE, 32'h1);
      rdc("result high", OFF_RESULT, 32'h1);
      rdc("trigger", OFF_SAMPLE, 32'h0);
      bus(1'b1, OFF_INTERRUPT_ENABLE_CLEAR, 32'h4);
      repeat (2) @(posedge hclk);
      cmp("irq off", 32'h0, 32'(irq));
      bus(1'b1, OFF_EV_UP, 32'h0);
      rdc("up clear", OFF_EV_UP, 32'h0);
      ain[psel] <= 6'd0;
      repeat (6) @(posedge hclk);
      rdc("down", OFF_EV_DOWN, 32'h1);
      rdc("up again", OFF_EV_UP, 32'h0);
      if (diff) begin
        bus(1'b1, OFF_STOP, 32'h1);
      end else begin
        bus(1'b1, OFF_EVENT_SHORTCUT_ENABLES, 32'h1 << SH_CROSSING_TO_HALT_SHORTCUT);
      end
      ain[psel] <= 6'd63;
      repeat (6) @(posedge hclk);
      cmp("halted", 32'h0, 32'(core_ctrl.power));
      bus(1'b1, OFF_EVENT_SHORTCUT_ENABLES, 32'h0);
      for (int e = 0; e < 4; e++) begin
        bus(1'b1, OFF_EV_READY + 12'(4 * e), 32'h0);
      end
    end
    results();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    cmp("run length", 32'h0, 32'h1);
    results();
  end
endmodule // comparator_control_logic_tb
